// >>> src/qec_pkg.sv
// quadrature encoder capture: shared constants, register map and carriers
// assumes a 25 MHz system clock and a 32-bit Avalon-MM register port
package qec_pkg;
  localparam int unsigned QEC_CLK_HZ = 25_000_000;
  localparam int unsigned QEC_SRC_HZ = 100_000_000;
  // sampling source runs this many times faster than clk_sys_i
  localparam int unsigned QEC_SRC_PER_CLK = QEC_SRC_HZ / QEC_CLK_HZ;
  localparam logic [3:0] QEC_SRC_SHIFT = 4'h2;
  localparam int unsigned QEC_DIV_W = 13;
  localparam int unsigned QEC_TMR_W = 16;
  localparam int unsigned QEC_FRAC_W = 12;
  localparam int unsigned QEC_CNT_W = 24;

  // register byte addresses
  localparam logic [4:0] QEC_OFS_CTRL = 5'h00;
  localparam logic [4:0] QEC_OFS_SERVO = 5'h04;
  localparam logic [4:0] QEC_OFS_PHASE = 5'h08;
  localparam logic [4:0] QEC_OFS_TRIG = 5'h0C;
  localparam logic [4:0] QEC_OFS_SFINE = 5'h10;
  localparam logic [4:0] QEC_OFS_TFINE = 5'h14;
  localparam logic [4:0] QEC_OFS_COUNT = 5'h18;

  // control field positions
  localparam int unsigned QEC_F_DEC = 0;
  localparam int unsigned QEC_F_DIV = 4;
  localparam int unsigned QEC_F_FSRC = 8;
  localparam int unsigned QEC_F_ATAN = 12;

  // decode_control values: bits 1:0 resolution, bit 2 sense, bit 3 three-phase
  localparam logic [1:0] QEC_RES_X4 = 2'h3;
  localparam logic [1:0] QEC_RES_X2 = 2'h2;
  localparam logic [1:0] QEC_RES_X1 = 2'h1;
  localparam logic [3:0] QEC_DEC_X4_CW = 4'h3;
  localparam logic [3:0] QEC_DEC_X4_CCW = 4'h7;
  localparam logic [3:0] QEC_DEC_X6_CW = 4'hB;
  localparam logic [3:0] QEC_DEC_X6_CCW = 4'hF;

  // reset values
  localparam logic [3:0] QEC_RST_DEC = QEC_DEC_X4_CW;
  localparam logic [3:0] QEC_RST_DIV = 4'h5;
  localparam logic [1:0] QEC_RST_FSRC = 2'h0;

  typedef struct packed {
    logic atan_en;
    logic [1:0] fsrc;
    logic [3:0] div;
    logic [3:0] dec;
  } qec_ctrl_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } qec_enc_t;

  typedef struct packed {
    logic servo;
    logic phase;
    logic trig;
  } qec_tick_t;
endpackage

// >>> src/qec_capture.sv
// quadrature encoder capture: decode, count, 1/T fraction, three coarse and two fine latches
// encoder and tick inputs are synchronous to clk_sys_i; ticks are 1-cycle pulses
// Overview of operation
// - decode_control 3 or 7 counts four per line, the two being opposite senses
// - decode_control also offers two-per-line and one-per-line resolutions
// - direction follows which of A and B leads the other
// - opposite sense reverses the sign of every count
// - fraction select 0 puts a 1/256-count timer estimate in latch low byte
// - servo, phase and trigger events each latch the position into their register
// - whole counts occupy the upper 24 bits of each coarse latch and the upper 20 bits of each fine latch
// - fraction select nonzero forces the latch low byte to zero
// - with timer extension, servo event latches a 12-bit-fraction fine position
// - with timer extension, trigger event latches a 12-bit-fraction fine position
// - arctangent enable does not derive any fraction from converter data
// - sampling runs at 100 MHz divided by two to the n, n 2..15 (0 and 1 sample every clk_sys_i), default 5
// - decode_control 11 and 15 count six per cycle from A, B, C
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
module qec_capture
  import qec_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // encoder lines and capture events
  input wire qec_pkg::qec_enc_t enc_i,
  input wire qec_pkg::qec_tick_t tick_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import qec_pkg::*;

  qec_ctrl_t ctrl;
  logic [31:0] servo_tick_position_latch;
  logic [31:0] phase_tick_position_latch;
  logic [31:0] trigger_position_latch;
  logic [31:0] servo_fine_position_latch;
  logic [31:0] trigger_fine_position_latch;
  logic [QEC_CNT_W-1:0] pos;
  logic [QEC_DIV_W-1:0] div_cnt;
  logic sample;
  qec_enc_t enc_q;
  logic [QEC_TMR_W-1:0] elapsed;
  logic [QEC_TMR_W-1:0] period;
  logic last_up;

  // sampling strobe: one sample every 2^n source clocks, at least every clk_sys_i
  logic [QEC_DIV_W-1:0] div_load;
  always_comb
  begin
    if (ctrl.div <= QEC_SRC_SHIFT)
      div_load = '0;
    else
      div_load = QEC_DIV_W'((1 << (ctrl.div - QEC_SRC_SHIFT)) - 1);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_cnt <= '0;
      sample <= 1'b0;
    end
    else if (div_cnt == '0)
    begin
      div_cnt <= div_load;
      sample <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt - 1'b1;
      sample <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      enc_q <= '0;
    else if (sample)
      enc_q <= enc_i;
  end

  // hall state to phase index 0..5; 7 marks an illegal all-high or all-low state
  function automatic logic [2:0] qec_hall_idx(input qec_enc_t e);
    unique case ({e.a, e.b, e.c})
      3'b100: qec_hall_idx = 3'h0;
      3'b110: qec_hall_idx = 3'h1;
      3'b010: qec_hall_idx = 3'h2;
      3'b011: qec_hall_idx = 3'h3;
      3'b001: qec_hall_idx = 3'h4;
      3'b101: qec_hall_idx = 3'h5;
      default: qec_hall_idx = 3'h7;
    endcase
  endfunction

  // step decision; up means count increments in the clockwise sense
  logic step;
  logic up_raw;
  logic up;
  logic a_chg;
  logic b_chg;
  logic [2:0] h_old;
  logic [2:0] h_new;
  always_comb
  begin
    a_chg = sample && (enc_i.a != enc_q.a);
    b_chg = sample && (enc_i.b != enc_q.b);
    h_old = qec_hall_idx(enc_q);
    h_new = qec_hall_idx(enc_i);
    step = 1'b0;
    up_raw = 1'b0;
    if (ctrl.dec[3])
    begin
      // six counts per cycle; skipped or illegal states are not counted
      if (sample && h_old != 3'h7 && h_new != 3'h7)
      begin
        if (h_new == ((h_old == 3'h5) ? 3'h0 : h_old + 3'h1))
        begin
          step = 1'b1;
          up_raw = 1'b1;
        end
        else if (h_old == ((h_new == 3'h5) ? 3'h0 : h_new + 3'h1))
          step = 1'b1;
      end
    end
    else
    begin
      // a double change is a lost sample and is dropped rather than guessed
      if (a_chg && !b_chg)
      begin
        up_raw = ~(enc_q.a ^ enc_i.b);
        unique case (ctrl.dec[1:0])
          QEC_RES_X4: step = 1'b1;
          QEC_RES_X2: step = 1'b1;
          QEC_RES_X1: step = enc_i.a;
          default: step = 1'b0;
        endcase
      end
      else if (b_chg && !a_chg && ctrl.dec[1:0] == QEC_RES_X4)
      begin
        step = 1'b1;
        up_raw = enc_i.a ^ enc_q.b;
      end
    end
    up = up_raw ^ ctrl.dec[2];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pos <= '0;
    else if (step)
      pos <= up ? pos + 1'b1 : pos - 1'b1;
  end

  // 1/T timer: time since last edge against the last edge interval
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      elapsed <= '0;
      period <= '0;
      last_up <= 1'b1;
    end
    else if (step)
    begin
      elapsed <= '0;
      period <= (&elapsed) ? elapsed : elapsed + 1'b1;
      last_up <= up;
    end
    else if (!(&elapsed))
      elapsed <= elapsed + 1'b1;
  end

  // fraction saturates just short of one count so it never passes the next edge;
  // arctangent enable is stored only, fraction always comes from the timer
  logic [QEC_FRAC_W-1:0] frac;
  logic [QEC_TMR_W+QEC_FRAC_W-1:0] quot;
  logic [QEC_CNT_W+QEC_FRAC_W-1:0] est;
  always_comb
  begin
    quot = '0;
    if (period != '0)
      quot = {elapsed, QEC_FRAC_W'(0)} / (QEC_TMR_W+QEC_FRAC_W)'(period);
    if (period == '0)
      frac = '0;
    else if (elapsed >= period)
      frac = '1;
    else
      frac = quot[QEC_FRAC_W-1:0];
    if (last_up)
      est = {pos, frac};
    else
      est = {pos, QEC_FRAC_W'(0)} - (QEC_CNT_W+QEC_FRAC_W)'(frac);
  end

  logic timer_ext;
  logic [31:0] coarse;
  always_comb
  begin
    timer_ext = (ctrl.fsrc == 2'h0);
    if (timer_ext)
      coarse = est[QEC_CNT_W+QEC_FRAC_W-1:4];
    else
      coarse = {pos, 8'h00};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      servo_tick_position_latch <= '0;
      phase_tick_position_latch <= '0;
      trigger_position_latch <= '0;
    end
    else
    begin
      if (tick_i.servo)
        servo_tick_position_latch <= coarse;
      if (tick_i.phase)
        phase_tick_position_latch <= coarse;
      if (tick_i.trig)
        trigger_position_latch <= coarse;
    end
  end

  // fine latches drop the top four count bits to make room for 12 fraction bits
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      servo_fine_position_latch <= '0;
      trigger_fine_position_latch <= '0;
    end
    else if (timer_ext)
    begin
      if (tick_i.servo)
        servo_fine_position_latch <= est[31:0];
      if (tick_i.trig)
        trigger_fine_position_latch <= est[31:0];
    end
  end

  // bus slave: every access waits exactly one cycle
  logic access;
  logic [31:0] rd_mux;
  always_comb
  begin
    access = avs_read_i || avs_write_i;
    unique case (avs_address_i)
      QEC_OFS_CTRL: rd_mux = 32'(ctrl.atan_en) << QEC_F_ATAN
                            | 32'(ctrl.fsrc) << QEC_F_FSRC
                            | 32'(ctrl.div) << QEC_F_DIV
                            | 32'(ctrl.dec) << QEC_F_DEC;
      QEC_OFS_SERVO: rd_mux = servo_tick_position_latch;
      QEC_OFS_PHASE: rd_mux = phase_tick_position_latch;
      QEC_OFS_TRIG: rd_mux = trigger_position_latch;
      QEC_OFS_SFINE: rd_mux = servo_fine_position_latch;
      QEC_OFS_TFINE: rd_mux = trigger_fine_position_latch;
      QEC_OFS_COUNT: rd_mux = {8'h00, pos};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !(access && avs_waitrequest_o);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      avs_readdata_o <= '0;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= rd_mux;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl.dec <= QEC_RST_DEC;
      ctrl.div <= QEC_RST_DIV;
      ctrl.fsrc <= QEC_RST_FSRC;
      ctrl.atan_en <= 1'b0;
    end
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == QEC_OFS_CTRL)
    begin
      ctrl.dec <= avs_writedata_i[QEC_F_DEC +: 4];
      ctrl.div <= avs_writedata_i[QEC_F_DIV +: 4];
      ctrl.fsrc <= avs_writedata_i[QEC_F_FSRC +: 2];
      ctrl.atan_en <= avs_writedata_i[QEC_F_ATAN];
    end
  end

  // checks
  bus_wait_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    access && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest did not drop for exactly one cycle");

  coarse_zero_frac_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.servo && !timer_ext |=> servo_tick_position_latch == {$past(pos), 8'h00})
    else $error("servo latch low byte not zero with timer extension off");

  servo_latch_pos_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.servo && timer_ext && last_up |=>
      servo_tick_position_latch[31:8] == $past(pos))
    else $error("servo latch whole count wrong");

  phase_latch_pos_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.phase && last_up |=> phase_tick_position_latch[31:8] == $past(pos))
    else $error("phase latch whole count wrong");

  trig_latch_pos_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.trig && !timer_ext |=> trigger_position_latch == {$past(pos), 8'h00})
    else $error("trigger latch wrong");

  fine_servo_pos_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.servo && timer_ext && last_up |=>
      servo_fine_position_latch[31:12] == $past(pos[19:0]))
    else $error("fine servo latch whole count wrong");

  fine_trig_pos_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tick_i.trig && timer_ext && last_up |=>
      trigger_fine_position_latch[31:12] == $past(pos[19:0]))
    else $error("fine trigger latch whole count wrong");

  // after an A edge, A and B differ exactly when A leads
  x4_step_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    a_chg && !b_chg && !ctrl.dec[3] && ctrl.dec[1:0] == QEC_RES_X4 |=>
      pos == $past(pos) + ($past(enc_i.a ^ enc_i.b ^ ctrl.dec[2]) ? 24'h000001 : 24'hFFFFFF))
    else $error("x4 step size or direction wrong");

  sample_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sample && ctrl.div == QEC_RST_DIV && $stable(ctrl.div) |=> !sample [*7])
    else $error("sampling strobe faster than the set divider");

  x1_one_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    a_chg && !enc_i.a && !ctrl.dec[3] && ctrl.dec[1:0] == QEC_RES_X1 |=> $stable(pos))
    else $error("x1 decode counted a falling edge");
endmodule

// >>> verif/qec_enc_model.sv
// encoder model: two-line quadrature source stepped on command
// assumes the bench calls move() from one thread at a time
module qec_enc_model
  import qec_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // encoder lines
  output qec_pkg::qec_enc_t enc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  initial enc_o = '0;
  // gray steps keep a and b a quarter cycle apart, a leading when forward
  task automatic move(input int n, input bit fwd, input int gap);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      enc_o <= '{a: ph[1] ^ ph[0], b: ph[1], c: 1'b0};
      repeat (gap) @(posedge clk_sys_i);
    end
  endtask
  logic [2:0] hi = 3'h0;
  // three-line hall source: 100,110,010,011,001,101 is the forward order
  task automatic hall(input int n, input bit fwd, input int gap);
    logic [17:0] tbl;
    tbl = 18'b101_001_011_010_110_100;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      if (fwd)
        hi = (hi == 3'h5) ? 3'h0 : hi + 3'h1;
      else
        hi = (hi == 3'h0) ? 3'h5 : hi - 3'h1;
      enc_o <= '{a: tbl[3*hi+2], b: tbl[3*hi+1], c: tbl[3*hi]};
      repeat (gap) @(posedge clk_sys_i);
    end
  endtask
endmodule

// >>> verif/tb.sv
// testbench for qec_capture: register port, encoder model, capture events
// assumes the one-wait avalon answer and single-cycle capture ticks
module tb;
  import qec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  qec_enc_t enc;
  qec_tick_t tick = '0;
  logic [4:0] adr = '0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic wait_q;
  logic [63:0] exp_q[$];
  logic [63:0] e_q;
  logic [23:0] pos = '0;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  always #20 clk_sys_i = ~clk_sys_i;

  qec_enc_model enc_m (.clk_sys_i(clk_sys_i), .enc_o(enc));

  qec_capture uut (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enc_i(enc),
    .tick_i(tick),
    .avs_address_i(adr),
    .avs_read_i(rd_q),
    .avs_write_i(wr_q),
    .avs_writedata_i(wdat),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_q)
  );

  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // read results are compared at the first edge that sees waitrequest low
  always @(posedge clk_sys_i)
  begin
    if (rd_q && wait_q === 1'b0)
    begin
      e_q = exp_q.pop_front();
      num_checks++;
      if ((rdat & e_q[63:32]) !== (e_q[31:0] & e_q[63:32]))
      begin
        failures++;
        $display("wrong value at %0t: addr %h got %h exp %h", $time, adr, rdat, e_q[31:0]);
      end
    end
  end

  // waits as long as the slave asks; only the hang guard ends a stuck access
  task automatic bus(input logic [4:0] a, input bit w, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    rd_q <= !w;
    wr_q <= w;
    wdat <= d;
    @(posedge clk_sys_i);
    while (wait_q !== 1'b0)
      @(posedge clk_sys_i);
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  // delta is the count change expected at the current decode setting
  task automatic mv(input int k, input bit f, input int g, input int delta);
    enc_m.move(k, f, g);
    pos = pos + 24'(delta);
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic pulse(input qec_tick_t t);
    @(posedge clk_sys_i);
    tick <= t;
    @(posedge clk_sys_i);
    tick <= '0;
  endtask

  initial
  begin
    void'($urandom(32'h4a72407a));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(QEC_OFS_CTRL, 32'h0000_0053, 32'hFFFF_FFFF);
    rd(5'h1C, 32'h0, 32'hFFFF_FFFF);
    n = $urandom_range(20, 5);
    // default divider samples every eighth cycle, so steps are spaced wider
    mv(n, 1'b1, 10, n);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    $display("test default_decode done");
    wr(QEC_OFS_CTRL, 32'h0000_0103);
    mv(3, 1'b0, 3, -3);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    pulse('{servo: 1'b1, phase: 1'b1, trig: 1'b1});
    rd(QEC_OFS_SERVO, {pos, 8'h00}, 32'hFFFF_FFFF);
    rd(QEC_OFS_PHASE, {pos, 8'h00}, 32'hFFFF_FFFF);
    rd(QEC_OFS_TRIG, {pos, 8'h00}, 32'hFFFF_FFFF);
    $display("test capture done");
    wr(QEC_OFS_CTRL, 32'h0000_0107);
    rd(QEC_OFS_CTRL, 32'h0000_0107, 32'hFFFF_FFFF);
    mv(4, 1'b1, 3, -4);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    $display("test reverse_sense done");
    wr(QEC_OFS_CTRL, 32'h0000_0102);
    mv(4, 1'b1, 3, 2);
    mv(4, 1'b0, 3, -2);
    mv(4, 1'b1, 3, 2);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    wr(QEC_OFS_CTRL, 32'h0000_0101);
    mv(8, 1'b1, 3, 2);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    $display("test low_resolution done");
    wr(QEC_OFS_CTRL, 32'h0000_1003);
    n = $urandom_range(12, 3);
    mv(n, 1'b1, 6, n);
    // last move was up, so the estimate never reaches the next whole count
    pulse('{servo: 1'b1, phase: 1'b0, trig: 1'b1});
    rd(QEC_OFS_SERVO, {pos, 8'h00}, 32'hFFFF_FF00);
    rd(QEC_OFS_TRIG, {pos, 8'h00}, 32'hFFFF_FF00);
    rd(QEC_OFS_SFINE, {pos[19:0], 12'h000}, 32'hFFFF_F000);
    rd(QEC_OFS_TFINE, {pos[19:0], 12'h000}, 32'hFFFF_F000);
    $display("test fine_latch done");
    // park on a hall state with counting off, so the switch itself counts nothing
    wr(QEC_OFS_CTRL, 32'h0000_0100);
    enc_m.hall(1, 1'b1, 3);
    wr(QEC_OFS_CTRL, 32'h0000_010B);
    n = $urandom_range(9, 2);
    enc_m.hall(n, 1'b1, 3);
    pos = pos + 24'(n);
    repeat (4) @(posedge clk_sys_i);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    wr(QEC_OFS_CTRL, 32'h0000_010F);
    enc_m.hall(2, 1'b1, 3);
    pos = pos - 24'h000002;
    repeat (4) @(posedge clk_sys_i);
    rd(QEC_OFS_COUNT, {8'h00, pos}, 32'h00FF_FFFF);
    $display("test hall_decode done");
    repeat (2) @(posedge clk_sys_i);
    end_sim();
  end
endmodule
